// file: rtl/tcpwm_defs.svh
// register offsets, field positions and reset values of the three channel pwm unit
`ifndef TCPWM_DEFS_SVH
`define TCPWM_DEFS_SVH

// ************************************************************
// global registers
// ************************************************************
`define TCPWM_OUTEN_OFS 12'h000
`define TCPWM_INVERT_OFS 12'h004
`define TCPWM_FLTEN_OFS 12'h008
`define TCPWM_STATE_OFS 12'h00C
`define TCPWM_RIS_OFS 12'h070
`define TCPWM_ICLR_OFS 12'h074
`define TCPWM_IEN_OFS 12'h078

// ************************************************************
// generator registers, base plus index times stride
// ************************************************************
`define TCPWM_GEN_BASE 12'h080
`define TCPWM_GEN_STRIDE 12'h020
`define TCPWM_G_CTL 3'h0
`define TCPWM_G_LOAD 3'h1
`define TCPWM_G_CMPA 3'h2
`define TCPWM_G_CMPB 3'h3
`define TCPWM_G_ACTA 3'h4
`define TCPWM_G_ACTB 3'h5
`define TCPWM_G_DBAND 3'h6
`define TCPWM_G_SEL 3'h7

// ************************************************************
// control field positions
// ************************************************************
`define TCPWM_CTL_RUN 0
`define TCPWM_CTL_UPDN 1
`define TCPWM_CTL_LSYNC 2
`define TCPWM_CTL_CSYNC 3
`define TCPWM_CTL_DBEN 4

// ************************************************************
// sizes and reset values
// ************************************************************
`define TCPWM_NGEN 3
`define TCPWM_NOUT 6
`define TCPWM_NEV 6
`define TCPWM_RST_16 16'h0000
`define TCPWM_RST_CTL 5'h00
`define TCPWM_RST_ACT 12'h000
`define TCPWM_RST_DB 8'h00
`define TCPWM_RST_OUT 6'h00

`endif

// file: rtl/tcpwm_pkg.sv
// types of the three channel pwm unit
package tcpwm_pkg;
    // action taken on an output when a counter or comparator event fires
    typedef enum logic [1:0] {ACT_NONE, ACT_TOGGLE, ACT_LOW, ACT_HIGH} tcpwm_act_type;
    // counter direction
    typedef enum logic {DIR_DOWN, DIR_UP} tcpwm_dir_type;
endpackage

// file: rtl/tcpwm_top.sv
// three channel pwm unit with dead band, output control, fault and apb registers
//
// Summary of operation
// R1 - three generators plus one shared output control
// R2 - generator: 16-bit counter, comparators, builder, deadband, selector
// R3 - two outputs: independent or complementary with deadband
// R4 - output control sets polarity and pin drive
// R5 - one fault input quickly shuts outputs down
// R6 - 16-bit load sets period; zero, load events
// R7 - comparator match events; actions build each output
// R8 - deadband bypassable, signals then pass unchanged
// R9 - per output enable, inversion, fault participation
// R10 - synced load/compare updates apply at zero
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tcpwm_defs.svh"

module tcpwm_top (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // power stage side
    input wire logic FAULT,
    output logic [5:0] PWM_OUT,
    // system side
    output logic [2:0] ADC_TRIG,
    output logic IRQ
);
    // ************************************************************
    // state
    // ************************************************************
    logic [4:0] ctl [`TCPWM_NGEN];
    logic [15:0] load_wr [`TCPWM_NGEN];
    logic [15:0] cmpa_wr [`TCPWM_NGEN];
    logic [15:0] cmpb_wr [`TCPWM_NGEN];
    logic [15:0] load_act [`TCPWM_NGEN];
    logic [15:0] cmpa_act [`TCPWM_NGEN];
    logic [15:0] cmpb_act [`TCPWM_NGEN];
    logic [11:0] act_a [`TCPWM_NGEN];
    logic [11:0] act_b [`TCPWM_NGEN];
    logic [15:0] dband [`TCPWM_NGEN];
    logic [13:0] sel [`TCPWM_NGEN];
    logic [15:0] cnt [`TCPWM_NGEN];
    tcpwm_pkg::tcpwm_dir_type dir [`TCPWM_NGEN];
    logic [1:0] raw [`TCPWM_NGEN];
    logic [1:0] raw_q [`TCPWM_NGEN];
    logic [7:0] db_cnt [`TCPWM_NGEN];
    logic [5:0] ev [`TCPWM_NGEN];
    logic [5:0] shaped;
    logic [5:0] out_en;
    logic [5:0] invert;
    logic [5:0] flt_en;
    logic [3:0] ris;
    logic [3:0] ien;
    logic [3:0] next_set;
    logic flt_meta;
    logic flt_sync;
    logic wr_go;
    logic rd_go;
    logic [31:0] rd_mux;
    logic rd_hit;

    // ************************************************************
    // helpers
    // ************************************************************
    // one action applied to the current level
    function automatic logic apply_act(input logic lvl, input logic [1:0] code);
        unique case (tcpwm_pkg::tcpwm_act_type'(code))
            tcpwm_pkg::ACT_NONE: apply_act = lvl;
            tcpwm_pkg::ACT_TOGGLE: apply_act = ~lvl;
            tcpwm_pkg::ACT_LOW: apply_act = 1'b0;
            tcpwm_pkg::ACT_HIGH: apply_act = 1'b1;
        endcase
    endfunction

    // events in order zero, load, cmpa up, cmpa down, cmpb up, cmpb down; later ones win
    function automatic logic build(input logic lvl, input logic [5:0] e,
                                   input logic [11:0] acts);
        logic v;
        v = lvl;
        for (int k = 0; k < `TCPWM_NEV; k++) begin
            if (e[k]) begin
                v = apply_act(v, acts[2*k +: 2]);
            end
        end
        build = v;
    endfunction

    // byte address of a generator register
    function automatic logic [11:0] gen_addr(input int g, input logic [2:0] idx);
        gen_addr = `TCPWM_GEN_BASE + 12'(g) * `TCPWM_GEN_STRIDE + {7'h00, idx, 2'b00};
    endfunction

    // ************************************************************
    // apb access
    // ************************************************************
    assign wr_go = PSEL & PENABLE & PREADY & PWRITE;
    assign rd_go = PSEL & PENABLE & ~PREADY;

    // read mux; unmapped addresses read zero and flag an error
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (PADDR)
            `TCPWM_OUTEN_OFS: rd_mux = {26'h000_0000, out_en};
            `TCPWM_INVERT_OFS: rd_mux = {26'h000_0000, invert};
            `TCPWM_FLTEN_OFS: rd_mux = {26'h000_0000, flt_en};
            `TCPWM_STATE_OFS: rd_mux = {25'h000_0000, flt_sync, PWM_OUT};
            `TCPWM_RIS_OFS: rd_mux = {28'h000_0000, ris};
            `TCPWM_ICLR_OFS: rd_mux = 32'h0000_0000; // write only
            `TCPWM_IEN_OFS: rd_mux = {28'h000_0000, ien};
            default: rd_hit = 1'b0;
        endcase
        for (int g = 0; g < `TCPWM_NGEN; g++) begin
            for (int r = 0; r < 8; r++) begin
                if (PADDR == gen_addr(g, 3'(r))) begin
                    rd_hit = 1'b1;
                    unique case (3'(r))
                        `TCPWM_G_CTL: rd_mux = {cnt[g], 11'h000, ctl[g]};
                        `TCPWM_G_LOAD: rd_mux = {16'h0000, load_wr[g]};
                        `TCPWM_G_CMPA: rd_mux = {16'h0000, cmpa_wr[g]};
                        `TCPWM_G_CMPB: rd_mux = {16'h0000, cmpb_wr[g]};
                        `TCPWM_G_ACTA: rd_mux = {20'h0_0000, act_a[g]};
                        `TCPWM_G_ACTB: rd_mux = {20'h0_0000, act_b[g]};
                        `TCPWM_G_DBAND: rd_mux = {16'h0000, dband[g]};
                        `TCPWM_G_SEL: rd_mux = {18'h0_0000, sel[g]};
                    endcase
                end
            end
        end
    end

    // one wait state: ready rises in the second access cycle with data and error
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= rd_go;
            PSLVERR <= rd_go & ~rd_hit;
            if (rd_go && !PWRITE) begin
                PRDATA <= rd_mux;
            end
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    // global output control, written only on the ready edge
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            out_en <= `TCPWM_RST_OUT;
            invert <= `TCPWM_RST_OUT;
            flt_en <= `TCPWM_RST_OUT;
            ien <= 4'h0;
        end else if (wr_go) begin
            if (PADDR == `TCPWM_OUTEN_OFS) out_en <= PWDATA[5:0];
            if (PADDR == `TCPWM_INVERT_OFS) invert <= PWDATA[5:0];
            if (PADDR == `TCPWM_FLTEN_OFS) flt_en <= PWDATA[5:0];
            if (PADDR == `TCPWM_IEN_OFS) ien <= PWDATA[3:0];
        end
    end

    // per generator settings; load and compare values land in the write copies
    always_ff @(posedge CLOCK) begin
        for (int g = 0; g < `TCPWM_NGEN; g++) begin
            if (!RST_N) begin
                ctl[g] <= `TCPWM_RST_CTL;
                load_wr[g] <= `TCPWM_RST_16;
                cmpa_wr[g] <= `TCPWM_RST_16;
                cmpb_wr[g] <= `TCPWM_RST_16;
                act_a[g] <= `TCPWM_RST_ACT;
                act_b[g] <= `TCPWM_RST_ACT;
                dband[g] <= `TCPWM_RST_16;
                sel[g] <= 14'h0000;
            end else if (wr_go) begin
                if (PADDR == gen_addr(g, `TCPWM_G_CTL)) ctl[g] <= PWDATA[4:0];
                if (PADDR == gen_addr(g, `TCPWM_G_LOAD)) load_wr[g] <= PWDATA[15:0];
                if (PADDR == gen_addr(g, `TCPWM_G_CMPA)) cmpa_wr[g] <= PWDATA[15:0];
                if (PADDR == gen_addr(g, `TCPWM_G_CMPB)) cmpb_wr[g] <= PWDATA[15:0];
                if (PADDR == gen_addr(g, `TCPWM_G_ACTA)) act_a[g] <= PWDATA[11:0];
                if (PADDR == gen_addr(g, `TCPWM_G_ACTB)) act_b[g] <= PWDATA[11:0];
                if (PADDR == gen_addr(g, `TCPWM_G_DBAND)) dband[g] <= PWDATA[15:0];
                if (PADDR == gen_addr(g, `TCPWM_G_SEL)) sel[g] <= PWDATA[13:0];
            end
        end
    end

    // active copies: immediate, or only at the zero event when synced,
    // so an up/down period never mixes old and new values; down mode reloads from the old load at that zero
    always_ff @(posedge CLOCK) begin
        for (int g = 0; g < `TCPWM_NGEN; g++) begin
            if (!RST_N) begin
                load_act[g] <= `TCPWM_RST_16;
                cmpa_act[g] <= `TCPWM_RST_16;
                cmpb_act[g] <= `TCPWM_RST_16;
            end else begin
                if (!ctl[g][`TCPWM_CTL_LSYNC] || ev[g][0]) begin // [R10]
                    load_act[g] <= load_wr[g];
                end
                if (!ctl[g][`TCPWM_CTL_CSYNC] || ev[g][0]) begin // [R10]
                    cmpa_act[g] <= cmpa_wr[g];
                    cmpb_act[g] <= cmpb_wr[g];
                end
            end
        end
    end

    // ************************************************************
    // counters and events
    // ************************************************************
    // down mode reloads at zero; up/down turns at load and at zero
    always_ff @(posedge CLOCK) begin
        for (int g = 0; g < `TCPWM_NGEN; g++) begin // [R1]
            if (!RST_N || !ctl[g][`TCPWM_CTL_RUN]) begin
                cnt[g] <= `TCPWM_RST_16;
                dir[g] <= tcpwm_pkg::DIR_UP;
            end else if (!ctl[g][`TCPWM_CTL_UPDN]) begin // [R2]
                dir[g] <= tcpwm_pkg::DIR_DOWN;
                cnt[g] <= (cnt[g] == 16'h0000) ? load_act[g] : cnt[g] - 16'h0001; // [R6]
            end else if (dir[g] == tcpwm_pkg::DIR_UP) begin
                if (cnt[g] >= load_act[g]) begin
                    dir[g] <= tcpwm_pkg::DIR_DOWN;
                    cnt[g] <= (cnt[g] == 16'h0000) ? 16'h0000 : cnt[g] - 16'h0001;
                end else begin
                    cnt[g] <= cnt[g] + 16'h0001;
                end
            end else if (cnt[g] == 16'h0000) begin
                dir[g] <= tcpwm_pkg::DIR_UP;
                cnt[g] <= (load_act[g] == 16'h0000) ? 16'h0000 : 16'h0001;
            end else begin
                cnt[g] <= cnt[g] - 16'h0001;
            end
        end
    end

    // counter and comparator events of the current count
    always_comb begin
        for (int g = 0; g < `TCPWM_NGEN; g++) begin
            logic up;
            logic run;
            // down mode counts every compare match as down, even in its first cycle
            up = (dir[g] == tcpwm_pkg::DIR_UP) & ctl[g][`TCPWM_CTL_UPDN];
            run = ctl[g][`TCPWM_CTL_RUN];
            ev[g][0] = run & (cnt[g] == 16'h0000); // [R6]
            ev[g][1] = run & (cnt[g] == load_act[g]); // [R6]
            ev[g][2] = run & (cnt[g] == cmpa_act[g]) & up; // [R7]
            ev[g][3] = run & (cnt[g] == cmpa_act[g]) & ~up; // [R7]
            ev[g][4] = run & (cnt[g] == cmpb_act[g]) & up; // [R7]
            ev[g][5] = run & (cnt[g] == cmpb_act[g]) & ~up; // [R7]
        end
    end

    // ************************************************************
    // waveform builder and dead band
    // ************************************************************
    // each output is a level changed only by its configured actions
    always_ff @(posedge CLOCK) begin
        for (int g = 0; g < `TCPWM_NGEN; g++) begin
            if (!RST_N) begin
                raw[g] <= 2'b00;
            end else begin
                raw[g][0] <= build(raw[g][0], ev[g], act_a[g]); // [R7] [R3]
                raw[g][1] <= build(raw[g][1], ev[g], act_b[g]); // [R7] [R3]
            end
        end
    end

    // dead band counter restarts on every edge of the a signal
    always_ff @(posedge CLOCK) begin
        for (int g = 0; g < `TCPWM_NGEN; g++) begin
            if (!RST_N) begin
                raw_q[g] <= 2'b00;
                db_cnt[g] <= `TCPWM_RST_DB;
            end else begin
                raw_q[g] <= raw[g];
                if (raw[g][0] != raw_q[g][0]) begin
                    db_cnt[g] <= 8'h01;
                end else if (db_cnt[g] != 8'hFF) begin
                    db_cnt[g] <= db_cnt[g] + 8'h01;
                end
            end
        end
    end

    // complementary pair delays each rising edge; bypass passes both signals
    always_comb begin
        for (int g = 0; g < `TCPWM_NGEN; g++) begin
            if (ctl[g][`TCPWM_CTL_DBEN]) begin // [R3]
                shaped[2*g] = raw_q[g][0] & (db_cnt[g] > dband[g][7:0]);
                shaped[2*g+1] = ~raw_q[g][0] & (db_cnt[g] > dband[g][15:8]);
            end else begin
                shaped[2*g +: 2] = raw_q[g]; // [R8]
            end
        end
    end

    // ************************************************************
    // fault and output control
    // ************************************************************
    // fault pin synchroniser; two cycles of latency is the floor here
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            flt_meta <= 1'b0;
            flt_sync <= 1'b0;
        end else begin
            flt_meta <= FAULT;
            flt_sync <= flt_meta;
        end
    end

    // polarity, enable and fault gating; a disabled or faulted pin sits low
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            PWM_OUT <= `TCPWM_RST_OUT;
        end else begin
            for (int i = 0; i < `TCPWM_NOUT; i++) begin
                PWM_OUT[i] <= out_en[i] & ~(flt_sync & flt_en[i]) // [R4] [R5] [R9]
                    & (shaped[i] ^ invert[i]); // [R9]
            end
        end
    end

    // ************************************************************
    // selector, triggers and interrupts
    // ************************************************************
    // low sel bits pick interrupt events, high ones converter triggers
    always_comb begin
        for (int g = 0; g < `TCPWM_NGEN; g++) begin
            next_set[g] = |(ev[g] & sel[g][5:0]); // [R2]
        end
        next_set[3] = flt_sync;
    end

    // trigger pulses for one cycle after each cycle with a selected event
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ADC_TRIG <= 3'h0;
        end else begin
            for (int g = 0; g < `TCPWM_NGEN; g++) begin
                ADC_TRIG[g] <= |(ev[g] & sel[g][13:8]); // [R2]
            end
        end
    end

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ris <= 4'h0;
        end else if (wr_go && PADDR == `TCPWM_ICLR_OFS) begin
            ris <= (ris & ~PWDATA[3:0]) | next_set;
        end else begin
            ris <= ris | next_set;
        end
    end

    // level interrupt from the enabled status bits
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(ris & ien);
        end
    end
endmodule
`default_nettype wire

// file: test/tcpwm_gate_model.sv
// gate driver model: raises the fault line and counts shoot-through cycles
`timescale 1ns/1ps
`default_nettype none
module tcpwm_gate_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // gate commands and bench trip request
    input wire logic [5:0] gate,
    input wire logic trip,
    // back to the unit and bench
    output logic fault,
    output int shoot
);
    // overcurrent flag that follows the trip request on a clock edge, like a desaturation detector
    always_ff @(posedge clock) begin
        if (!rst_n) fault <= 1'b0;
        else fault <= trip;
    end
    // both switches of one leg on shorts the supply
    always_ff @(posedge clock) begin
        if (!rst_n) shoot <= 0;
        else if (|(gate[4:0] & gate[5:1] & 5'b1_0101)) shoot <= shoot + 1;
    end
endmodule
`default_nettype wire

// file: test/tcpwm_top_assertions.sv
// pin level assertions for the three channel pwm unit, bound to its top
`timescale 1ns/1ps
`default_nettype none
`include "tcpwm_defs.svh"
module tcpwm_top_checker (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // pins
    input wire logic FAULT,
    input wire logic [5:0] PWM_OUT,
    input wire logic [2:0] ADC_TRIG,
    input wire logic IRQ
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    logic [5:0] oe, oe1, oe2, oe3, flt;
    // ************************************************************
    // shadow of enables from completed writes
    // ************************************************************
    // four deep history; the pins lag a register write by one clock
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            {oe, oe1, oe2, oe3, flt} <= 30'h0000_0000;
        end else begin
            {oe1, oe2, oe3} <= {oe, oe1, oe2};
            if (PSEL && PENABLE && PREADY && PWRITE && !PSLVERR) begin
                if (PADDR == `TCPWM_OUTEN_OFS) oe <= PWDATA[5:0];
                if (PADDR == `TCPWM_FLTEN_OFS) flt <= PWDATA[5:0];
            end
        end
    end
    sequence access_wait;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence fault_held;
        FAULT [*3];
    endsequence
    // ************************************************************
    // assertions
    // ************************************************************
    a_ready_wait: assert property (access_wait |=> PREADY)
        else $error("ready missing after one wait state");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    a_ready_cause: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && PENABLE))
        else $error("ready outside an access phase");
    a_slverr_ready: assert property (PSLVERR |-> PREADY)
        else $error("error response without ready");
    a_unmapped_error: assert property (PREADY && PADDR == 12'h010 |-> PSLVERR)
        else $error("unmapped access not refused");
    a_fault_shutdown: assert property (fault_held |=> (PWM_OUT & flt) == 6'h00)
        else $error("fault did not shut outputs down");
    a_disabled_low: assert property ((PWM_OUT & ~(oe | oe1 | oe2 | oe3)) == 6'h00)
        else $error("disabled output driven");
    a_reset_quiet: assert property ($rose(RST_N) |-> PWM_OUT == 6'h00 && !IRQ && !ADC_TRIG)
        else $error("outputs active out of reset");
endmodule
bind tcpwm_top tcpwm_top_checker u_tcpwm_top_checker (.CLOCK(CLOCK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .FAULT(FAULT), .PWM_OUT(PWM_OUT),
    .ADC_TRIG(ADC_TRIG), .IRQ(IRQ));
`default_nettype wire

// file: test/tcpwm_top_tb.sv
// self-checking bench for the three channel pwm unit
`timescale 1ns/1ps
`default_nettype none
`include "tcpwm_defs.svh"
module tcpwm_top_tb;
    logic clk, rst_n, psel, penable, pwrite, fault, trip, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] pwm;
    logic [2:0] trig;
    int errors, samples_checked, cycles, shoot;
    int hi[6];
    int tr[3];
    tcpwm_top u_tcpwm_top (.CLOCK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .FAULT(fault), .PWM_OUT(pwm), .ADC_TRIG(trig), .IRQ(irq));
    tcpwm_gate_model u_tcpwm_gate_model (.clock(clk), .rst_n(rst_n), .gate(pwm),
        .trip(trip), .fault(fault), .shoot(shoot));
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer; the wait for ready is bounded by the hang guard only
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [11:0] ga(input int g, input int r);
        return 12'(`TCPWM_GEN_BASE + `TCPWM_GEN_STRIDE * g + 4 * r);
    endfunction
    // counts high samples per pin and trigger pulses, at the settled falling edge
    task automatic measure(input int n);
        hi = '{default: 0};
        tr = '{default: 0};
        repeat (n) begin
            @(negedge clk);
            for (int b = 0; b < 6; b++) hi[b] += pwm[b];
            for (int b = 0; b < 3; b++) tr[b] += trig[b];
        end
    endtask
    // load of 3 everywhere; action word serves both outputs
    task automatic setup(input int g, input logic [31:0] ctl, act, cmp, sel);
        apb(1, ga(g, `TCPWM_G_LOAD), 32'h0000_0003);
        apb(1, ga(g, `TCPWM_G_CMPA), cmp);
        apb(1, ga(g, `TCPWM_G_ACTA), act);
        apb(1, ga(g, `TCPWM_G_ACTB), act);
        apb(1, ga(g, `TCPWM_G_SEL), sel);
        apb(1, ga(g, `TCPWM_G_CTL), ctl);
        repeat (8) @(posedge clk);
    endtask
    task automatic test_regs();
        for (int i = 0; i < 3; i++) begin
            apb(0, 12'(4 * i), 32'h0000_0000);
            check(rd, 32'h0000_0000);
        end
        apb(1, `TCPWM_FLTEN_OFS, 32'h0000_002A);
        apb(0, `TCPWM_FLTEN_OFS, 32'h0000_0000);
        check(rd, 32'h0000_002A);
        apb(1, 12'h010, 32'hFFFF_FFFF);
        apb(0, 12'h010, 32'h0000_0000);
        check({rd[30:0], err}, 32'h0000_0001);
        apb(1, `TCPWM_FLTEN_OFS, 32'h0000_0000);
        $display("test_regs done");
    endtask
    // down count 3..0, high on zero, low on compare 1 going down: 3 of 4 high
    task automatic test_wave();
        for (int g = 0; g < 3; g++) begin
            apb(1, `TCPWM_OUTEN_OFS, 32'(3 << (2 * g)));
            setup(g, 32'h0000_0001, 32'h0000_0083, 32'h0000_0001, 32'h0000_0101);
            measure(8);
            check(hi[2 * g], 6);
            check(hi[2 * g + 1], 6);
            check(tr[g], 2);
            apb(1, `TCPWM_IEN_OFS, 32'h0000_0000);
            repeat (2) @(posedge clk);
            check(irq, 0);
            apb(1, `TCPWM_IEN_OFS, 32'(1 << g));
            repeat (2) @(posedge clk);
            check(irq, 1);
            apb(1, ga(g, `TCPWM_G_CTL), 32'h0000_0000);
            apb(1, `TCPWM_ICLR_OFS, 32'h0000_000F);
            apb(0, `TCPWM_RIS_OFS, 32'h0000_0000);
            check(rd, 0);
            check(irq, 0);
        end
        $display("test_wave done");
    endtask
    task automatic test_dband();
        int n;
        apb(1, `TCPWM_OUTEN_OFS, 32'h0000_0003);
        apb(1, `TCPWM_INVERT_OFS, 32'h0000_0001);
        setup(0, 32'h0000_0001, 32'h0000_0083, 32'h0000_0001, 32'h0000_0000);
        measure(8);
        check(hi[0], 2);
        check(hi[1], 6);
        apb(1, `TCPWM_INVERT_OFS, 32'h0000_0000);
        apb(1, ga(0, `TCPWM_G_DBAND), 32'h0000_0001);
        apb(1, ga(0, `TCPWM_G_CTL), 32'h0000_0011);
        repeat (8) @(posedge clk);
        n = shoot;
        measure(8);
        check(hi[0], 4);
        check(hi[1], 2);
        check(shoot - n, 0);
        apb(1, ga(0, `TCPWM_G_CTL), 32'h0000_0000);
        $display("test_dband done");
    endtask
    // up/down 0..3..0 has a period of 6, high from zero until the load event
    task automatic test_updown();
        apb(1, `TCPWM_OUTEN_OFS, 32'h0000_0004);
        setup(1, 32'h0000_0003, 32'h0000_000B, 32'h0000_0000, 32'h0000_0100);
        measure(12);
        check(hi[2], 6);
        check(tr[1], 2);
        apb(1, ga(1, `TCPWM_G_CTL), 32'h0000_0000);
        $display("test_updown done");
    endtask
    task automatic test_fault();
        apb(1, `TCPWM_OUTEN_OFS, 32'h0000_0003);
        apb(1, `TCPWM_FLTEN_OFS, 32'h0000_0001);
        apb(1, `TCPWM_IEN_OFS, 32'h0000_0008);
        setup(0, 32'h0000_0001, 32'h0000_0083, 32'h0000_0001, 32'h0000_0000);
        trip <= 1'b1;
        repeat (5) @(posedge clk);
        measure(8);
        check(hi[0], 0);
        check(hi[1], 6);
        check(irq, 1);
        apb(1, `TCPWM_ICLR_OFS, 32'h0000_0008);
        apb(0, `TCPWM_RIS_OFS, 32'h0000_0000);
        check(rd[3], 1);
        trip <= 1'b0;
        repeat (5) @(posedge clk);
        apb(1, `TCPWM_ICLR_OFS, 32'h0000_0008);
        apb(0, `TCPWM_RIS_OFS, 32'h0000_0000);
        check(rd[3], 0);
        check(irq, 0);
        measure(8);
        check(hi[0], 6);
        apb(1, ga(0, `TCPWM_G_CTL), 32'h0000_0000);
        $display("test_fault done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // reset for 8 clocks, then the scenarios
    initial begin
        {rst_n, psel, penable, pwrite, trip} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        test_regs();
        test_wave();
        test_dband();
        test_updown();
        test_fault();
        results();
    end
endmodule
`default_nettype wire
